// >>> common/pin_function_pkg.sv
// Notes on behaviour
// (RULE1) Third pin function field is bits 8:6, reset code 000b, arbitration.
// (RULE2) Code 000b: third pin is a tri-state arbitration line, never driven together.
// (RULE3) Code 001b: third pin is enable input; high enables, low disables.
// (RULE4) Code 010b: third pin pulled low open-drain once a port is attached.
// (RULE5) Code 011b: third pin high after enable falls, floats after 22 minutes.
// (RULE6) Code 101b: third pin pulled low while third contract selected; 100b orientation.
// (RULE7) Code 111b: third pin 10 kHz PWM current limit; 110b current sense.
// (RULE8) Board supplies a pull-up on the third pin for the PWM function.
// (RULE9) Second pin function field is bits 5:3, reset code 110b, power sharing.
// (RULE10) Code 000b: second pin asserted to enable 12 V in QC2.0 mode.
// (RULE11) Code 001b: second pin low for first CC line, released for second.
// (RULE12) Second pin: 010b held low, 110b power sharing, 111b battery sense.
// (RULE13) First pin function field is bits 2:0, reset code 001b, interrupt input.
// (RULE14) Code 000b: first pin low while second contract selected or 9 V asked; the code honours 9 V only in QC2.0 mode.
// (RULE15) Code 001b: first pin high impedance, monitored as converter alert input.
// (RULE16) First pin held low at 010b, released open-drain at 011b.
// (RULE17) Code 100b: first pin drives voltage select; higher codes reserved.
// (RULE18) Control register is read/write at register index 0x0D.
// (RULE19) Reserved codes leave the pin high impedance with no function.
package pin_function_pkg;

  localparam logic [7:0]  CTL_INDEX    = 8'h0D;
  localparam logic [7:0]  STAT_INDEX   = 8'h10;
  localparam logic [7:0]  DUTY_INDEX   = 8'h11;
  localparam logic [7:0]  CTL_ADDR     = {CTL_INDEX[5:0], 2'b00};
  localparam logic [7:0]  STAT_ADDR    = {STAT_INDEX[5:0], 2'b00};
  localparam logic [7:0]  DUTY_ADDR    = {DUTY_INDEX[5:0], 2'b00};

  localparam int unsigned FN_W         = 3;
  localparam int unsigned F3_LSB       = 6;
  localparam int unsigned F2_LSB       = 3;
  localparam int unsigned F1_LSB       = 0;
  localparam logic [15:0] CTL_RESET    = 16'h0031;
  localparam logic [7:0]  DUTY_RESET   = 8'h80;

  localparam logic [2:0]  CONTRACT_SECOND = 3'h2;
  localparam logic [2:0]  CONTRACT_THIRD  = 3'h3;

  localparam longint unsigned CLK_HZ        = 64'd125_000_000;
  localparam longint unsigned OFF_DELAY_MIN = 64'd22;
  localparam longint unsigned OFF_DELAY_CYC = OFF_DELAY_MIN * 64'd60 * CLK_HZ;
  localparam int unsigned     TIMER_W       = 38;
  localparam longint unsigned PWM_FREQ_HZ   = 64'd10_000;
  localparam int unsigned     PWM_PERIOD_CYC = 32'(CLK_HZ / PWM_FREQ_HZ);
  localparam int unsigned     PWM_W         = 14;

  typedef enum logic [2:0] {
    P3_ARB = 3'h0, P3_ENABLE = 3'h1, P3_ATTACH = 3'h2, P3_OFF_DELAY = 3'h3,
    P3_ORIENT = 3'h4, P3_PDO3 = 3'h5, P3_SENSE = 3'h6, P3_PWM = 3'h7
  } third_fn_t;

  typedef enum logic [2:0] {
    P2_QC12 = 3'h0, P2_ORIENT = 3'h1, P2_LOW = 3'h2, P2_SHARE = 3'h6, P2_BATT = 3'h7
  } second_fn_t;

  typedef enum logic [2:0] {
    P1_PDO2 = 3'h0, P1_ALERT = 3'h1, P1_LOW = 3'h2, P1_OPEN = 3'h3, P1_VSEL = 3'h4
  } first_fn_t;

  typedef struct packed {
    logic out;
    logic oe;
  } pin_drive_t;

  typedef struct packed {
    logic       alert;
    logic       arb_owned;
    logic       delay_hold;
    logic       enabled;
    logic [2:0] pin_level;
  } status_t;

endpackage

// >>> design/off_delay_timer.sv
`timescale 1ns/1ns
module off_delay_timer
  import pin_function_pkg::*;
#(
  parameter longint unsigned HOLD_CYC = OFF_DELAY_CYC
) (
  input  wire logic clk_i,     // System clock
  input  wire logic rst_i,     // Synchronous reset, active high
  input  wire logic arm_i,     // Off-delay function selected
  input  wire logic enable_i,  // Enable level
  output logic      hold_o     // Keep the output driven high
);

  logic [TIMER_W-1:0] cnt;
  wire                last = cnt == TIMER_W'(HOLD_CYC - 64'd1);

  // Restart on every enable; count only after it has fallen
  always_ff @(posedge clk_i) begin
    if (rst_i || !arm_i) begin
      cnt    <= '0;
      hold_o <= 1'b0;
    end else if (enable_i) begin
      cnt    <= '0;
      hold_o <= 1'b1;
    end else if (hold_o) begin
      cnt    <= cnt + TIMER_W'(1);
      hold_o <= !last;  // see RULE5
    end
  end

endmodule

// >>> design/pin_function_select.sv
// Chosen here: the address map and the Wishbone register port.
`timescale 1ns/1ns
module pin_function_select
  import pin_function_pkg::*;
#(
  parameter longint unsigned OFF_DELAY_CYCLES = OFF_DELAY_CYC,
  parameter int unsigned     PWM_PERIOD       = PWM_PERIOD_CYC
) (
  input  wire logic        clk_i,                           // System clock
  input  wire logic        rst_i,                           // Sync reset
  input  wire logic        wb_cyc_i,                        // Bus cycle
  input  wire logic        wb_stb_i,                        // Strobe
  input  wire logic        wb_we_i,                         // Write
  input  wire logic [7:0]  wb_adr_i,                        // Byte address
  input  wire logic [3:0]  wb_sel_i,                        // Byte lanes
  input  wire logic [31:0] wb_dat_i,                        // Write data
  output logic      [31:0] wb_dat_o,                        // Read data
  output logic             wb_ack_o,                        // Acknowledge
  input  wire logic        third_multi_pin_i,               // Pad level
  output logic             third_multi_pin_o,               // Pad drive value
  output logic             third_multi_pin_oe_o,            // Pad drive enable
  input  wire logic        second_multi_pin_i,              // Pad level
  output logic             second_multi_pin_o,              // Pad drive value
  output logic             second_multi_pin_oe_o,           // Pad drive enable
  input  wire logic        first_multi_pin_i,               // Pad level
  output logic             first_multi_pin_o,               // Pad drive value
  output logic             first_multi_pin_oe_o,            // Pad drive enable
  input  wire logic        attached_i,                      // Port attached
  input  wire logic        cc_second_i,                     // Second CC line in use
  input  wire logic [2:0]  contract_sel_i,                  // Selected contract
  input  wire logic        qc2_mode_i,                      // QC2.0 mode active
  input  wire logic        quick_twelve_volt_enable_i,      // 12 V asked
  input  wire logic        quick_nine_volt_enable_i,        // 9 V asked
  input  wire logic        voltage_select_line_one_i,       // Select level
  input  wire logic        power_budget_share_claim_i,      // Claim share line
  input  wire logic        bus_master_arbitration_claim_i,  // Want bus
  input  wire logic        ext_enable_i,                    // Enable from other pin
  output logic             device_enable_o,                 // Device enabled
  output logic             bus_master_arbitration_grant_o,  // Bus owned
  output logic             converter_alert_seen_o,          // Alert asserted
  output logic             power_budget_share_level_o,      // Share line level
  output logic             battery_level_sense_o,           // Battery sense level
  output logic             line_drop_current_sense_o        // Sense pin level
);

  logic [15:0]      ctl;
  logic [7:0]       duty;
  logic [2:0]       sync1;
  logic [2:0]       pad_lvl;
  logic [PWM_W-1:0] pwm_cnt;
  logic             delay_hold;
  pin_drive_t       next_p3;
  pin_drive_t       next_p2;
  pin_drive_t       next_p1;
  status_t          stat;

  third_fn_t  fn3;
  second_fn_t fn2;
  first_fn_t  fn1;
  assign fn3 = third_fn_t'(ctl[F3_LSB +: FN_W]);
  assign fn2 = second_fn_t'(ctl[F2_LSB +: FN_W]);
  assign fn1 = first_fn_t'(ctl[F1_LSB +: FN_W]);

  // Pad inputs cross into the clock domain through two flops each
  wire [2:0] pad_raw = {third_multi_pin_i, second_multi_pin_i, first_multi_pin_i};
  for (genvar i = 0; i < 3; i++) begin : g_sync
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        sync1[i]   <= 1'b1;
        pad_lvl[i] <= 1'b1;
      end else begin
        sync1[i]   <= pad_raw[i];
        pad_lvl[i] <= sync1[i];
      end
    end
  end

  // Wishbone slave: one wait state, unmapped reads return zero
  wire        req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Writes land at the edge on which the master sees ack
  wire        wr       = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  wire        hit_ctl  = wb_adr_i == CTL_ADDR;
  wire        hit_stat = wb_adr_i == STAT_ADDR;
  wire        hit_duty = wb_adr_i == DUTY_ADDR;
  wire [31:0] rd_word  = hit_ctl  ? {16'h0000, ctl} :
                         hit_stat ? {25'h0000000, stat} :
                         hit_duty ? {24'h000000, duty} : 32'h00000000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rd_word : 32'h00000000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl  <= CTL_RESET;  // see RULE1 RULE9 RULE13
      duty <= DUTY_RESET;
    end else begin
      if (wr && hit_ctl && wb_sel_i[0]) ctl[7:0] <= wb_dat_i[7:0];  // see RULE18
      if (wr && hit_ctl && wb_sel_i[1]) ctl[15:8] <= wb_dat_i[15:8];
      if (wr && hit_duty && wb_sel_i[0]) duty <= wb_dat_i[7:0];
    end
  end

  // Enable level comes from the third pin only in its enable mode
  wire en_level = (fn3 == P3_ENABLE) ? pad_lvl[2] : ext_enable_i;  // see RULE3

  off_delay_timer #(
    .HOLD_CYC (OFF_DELAY_CYCLES)
  ) u_off_delay (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .arm_i    (fn3 == P3_OFF_DELAY),
    .enable_i (en_level),
    .hold_o   (delay_hold)
  );

  // Free-running PWM; the pin is released for the high part of the period
  wire [21:0]      pwm_prod = 22'(14'(PWM_PERIOD)) * 22'(duty);
  wire [PWM_W-1:0] pwm_high = pwm_prod[21:8];
  wire             pwm_wrap = pwm_cnt == PWM_W'(PWM_PERIOD - 1);
  wire             pwm_low  = pwm_cnt >= pwm_high;

  always_ff @(posedge clk_i) begin
    if (rst_i) pwm_cnt <= '0;
    else pwm_cnt <= pwm_wrap ? '0 : pwm_cnt + PWM_W'(1);  // see RULE7
  end

  // Take the line only while it is seen high, then keep it while claimed
  wire next_arb = (fn3 == P3_ARB) && bus_master_arbitration_claim_i &&
                  (bus_master_arbitration_grant_o || pad_lvl[2]);  // see RULE2
  wire pdo3_sel = contract_sel_i == CONTRACT_THIRD;
  wire pdo2_pull = (contract_sel_i == CONTRACT_SECOND) ||
                   (qc2_mode_i && quick_nine_volt_enable_i);
  wire qc12_level = qc2_mode_i && quick_twelve_volt_enable_i;

  always_comb begin
    next_p3 = '{out: 1'b0, oe: 1'b0};
    unique case (fn3)
      P3_ARB:       next_p3.oe = next_arb;  // see RULE2
      P3_ENABLE:    next_p3.oe = 1'b0;  // see RULE3
      P3_ATTACH:    next_p3.oe = attached_i;  // see RULE4
      P3_OFF_DELAY: next_p3 = '{out: delay_hold, oe: delay_hold};  // see RULE5
      P3_ORIENT:    next_p3.oe = !cc_second_i;  // see RULE6
      P3_PDO3:      next_p3.oe = pdo3_sel;  // see RULE6
      P3_SENSE:     next_p3.oe = 1'b0;  // see RULE7
      P3_PWM:       next_p3.oe = pwm_low;  // see RULE7
    endcase
  end

  always_comb begin
    next_p2 = '{out: 1'b0, oe: 1'b0};
    unique case (fn2)
      P2_QC12:   next_p2 = '{out: qc12_level, oe: 1'b1};  // see RULE10
      P2_ORIENT: next_p2.oe = !cc_second_i;  // see RULE11
      P2_LOW:    next_p2.oe = 1'b1;  // see RULE12
      P2_SHARE:  next_p2.oe = power_budget_share_claim_i;  // see RULE12
      P2_BATT:   next_p2.oe = 1'b0;  // see RULE12
      default:   next_p2.oe = 1'b0;  // see RULE19
    endcase
  end

  always_comb begin
    next_p1 = '{out: 1'b0, oe: 1'b0};
    unique case (fn1)
      P1_PDO2:  next_p1.oe = pdo2_pull;  // see RULE14
      P1_ALERT: next_p1.oe = 1'b0;  // see RULE15
      P1_LOW:   next_p1.oe = 1'b1;  // see RULE16
      P1_OPEN:  next_p1.oe = 1'b0;  // see RULE16
      P1_VSEL:  next_p1 = '{out: voltage_select_line_one_i, oe: 1'b1};  // see RULE17
      default:  next_p1.oe = 1'b0;  // see RULE19
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {third_multi_pin_o, third_multi_pin_oe_o}   <= 2'b00;
      {second_multi_pin_o, second_multi_pin_oe_o} <= 2'b00;
      {first_multi_pin_o, first_multi_pin_oe_o}   <= 2'b00;
    end else begin
      {third_multi_pin_o, third_multi_pin_oe_o}   <= next_p3;
      {second_multi_pin_o, second_multi_pin_oe_o} <= next_p2;
      {first_multi_pin_o, first_multi_pin_oe_o}   <= next_p1;
    end
  end

  // Levels seen on input-mode pins, reported only in the matching mode; device_enable_o follows ext_enable_i outside the enable mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      device_enable_o                <= 1'b0;
      bus_master_arbitration_grant_o <= 1'b0;
      converter_alert_seen_o         <= 1'b0;
      power_budget_share_level_o     <= 1'b0;
      battery_level_sense_o          <= 1'b0;
      line_drop_current_sense_o      <= 1'b0;
    end else begin
      device_enable_o                <= en_level;  // see RULE3
      bus_master_arbitration_grant_o <= next_arb;
      converter_alert_seen_o         <= (fn1 == P1_ALERT) && !pad_lvl[0];  // see RULE15
      power_budget_share_level_o     <= (fn2 == P2_SHARE) && pad_lvl[1];
      battery_level_sense_o          <= (fn2 == P2_BATT) && pad_lvl[1];
      line_drop_current_sense_o      <= (fn3 == P3_SENSE) && pad_lvl[2];
    end
  end

  assign stat = '{alert: converter_alert_seen_o, arb_owned: bus_master_arbitration_grant_o,
                  delay_hold: delay_hold, enabled: device_enable_o, pin_level: pad_lvl};

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_third_reset_code: assert property ($past(rst_i) |-> ctl[8:6] == 3'h0)  // see RULE1
    else $error("third pin field not 000b after reset");
  a_second_reset_code: assert property ($past(rst_i) |-> ctl[5:3] == 3'h6)  // see RULE9
    else $error("second pin field not 110b after reset");
  a_first_reset_code: assert property ($past(rst_i) |-> ctl[2:0] == 3'h1)  // see RULE13
    else $error("first pin field not 001b after reset");
  a_arb_no_clash: assert property (fn3 == P3_ARB && $rose(third_multi_pin_oe_o)  // see RULE2
    |-> $past(pad_lvl[2]) && !third_multi_pin_o)
    else $error("arbitration line taken while held low");
  a_arb_release: assert property (fn3 == P3_ARB && !bus_master_arbitration_claim_i  // see RULE2
    |=> !third_multi_pin_oe_o)
    else $error("arbitration line kept without a claim");
  a_enable_follows: assert property (fn3 == P3_ENABLE  // see RULE3
    |=> device_enable_o == $past(pad_lvl[2]) && !third_multi_pin_oe_o)
    else $error("enable does not follow third pin");
  a_enable_ext: assert property (fn3 != P3_ENABLE  // see RULE3
    |=> device_enable_o == $past(ext_enable_i))
    else $error("enable does not follow the outside level");
  a_attach_pull: assert property (fn3 == P3_ATTACH && attached_i  // see RULE4
    |=> third_multi_pin_oe_o && !third_multi_pin_o)
    else $error("attach not pulled low");
  a_attach_release: assert property (fn3 == P3_ATTACH && !attached_i  // see RULE4
    |=> !third_multi_pin_oe_o)
    else $error("attach pin held without attachment");
  a_off_delay_hold: assert property ((fn3 == P3_OFF_DELAY && en_level) [*2]  // see RULE5
    |=> third_multi_pin_oe_o && third_multi_pin_o)
    else $error("off-delay output not high while enabled");
  a_delay_expiry: assert property (fn3 == P3_OFF_DELAY && !delay_hold  // see RULE5
    |=> !third_multi_pin_oe_o)
    else $error("off-delay output not released after expiry");
  a_orient_third: assert property (fn3 == P3_ORIENT  // see RULE6
    |=> third_multi_pin_oe_o == !$past(cc_second_i) && !third_multi_pin_o)
    else $error("third pin orientation output wrong");
  a_pdo3_pull: assert property (fn3 == P3_PDO3 && pdo3_sel  // see RULE6
    |=> third_multi_pin_oe_o && !third_multi_pin_o)
    else $error("third contract output not pulled low");
  a_sense_input: assert property (fn3 == P3_SENSE  // see RULE7
    |=> !third_multi_pin_oe_o && line_drop_current_sense_o == $past(pad_lvl[2]))
    else $error("sense pin driven or level lost");
  a_pwm_zero_duty: assert property (fn3 == P3_PWM && duty == 8'h00  // see RULE7
    |=> third_multi_pin_oe_o && !third_multi_pin_o)
    else $error("pwm output released at zero duty");
  a_pwm_wraps: assert property (pwm_wrap |=> pwm_cnt == '0 ##1 pwm_cnt == PWM_W'(1))  // see RULE7
    else $error("pwm period counter does not wrap");
  a_qc12_drive: assert property (fn2 == P2_QC12  // see RULE10
    |=> second_multi_pin_oe_o
    && second_multi_pin_o == $past(qc2_mode_i && quick_twelve_volt_enable_i))
    else $error("12 V enable not driven");
  a_orient_second: assert property (fn2 == P2_ORIENT  // see RULE11
    |=> second_multi_pin_oe_o == !$past(cc_second_i))
    else $error("orientation output wrong");
  a_second_low: assert property (fn2 == P2_LOW  // see RULE12
    |=> second_multi_pin_oe_o && !second_multi_pin_o)
    else $error("second pin not held low");
  a_share_pin: assert property (fn2 == P2_SHARE  // see RULE12
    |=> second_multi_pin_oe_o == $past(power_budget_share_claim_i) && !second_multi_pin_o
    && power_budget_share_level_o == $past(pad_lvl[1]))
    else $error("share pin wrong");
  a_batt_input: assert property (fn2 == P2_BATT  // see RULE12
    |=> !second_multi_pin_oe_o && battery_level_sense_o == $past(pad_lvl[1]))
    else $error("battery sense pin driven or level lost");
  a_second_reserved: assert property (ctl[F2_LSB +: FN_W] inside {3'h3, 3'h4, 3'h5}  // see RULE19
    |=> !second_multi_pin_oe_o)
    else $error("reserved code drives second pin");
  a_pdo2_pull: assert property (fn1 == P1_PDO2  // see RULE14
    |=> first_multi_pin_oe_o == $past(pdo2_pull) && !first_multi_pin_o)
    else $error("second contract output wrong");
  a_alert_hiz: assert property (fn1 == P1_ALERT && !pad_lvl[0]  // see RULE15
    |=> !first_multi_pin_oe_o && converter_alert_seen_o)
    else $error("alert input not monitored");
  a_alert_idle: assert property (fn1 == P1_ALERT && pad_lvl[0]  // see RULE15
    |=> !first_multi_pin_oe_o && !converter_alert_seen_o)
    else $error("alert seen while input high");
  a_first_modes: assert property (fn1 == P1_LOW  // see RULE16
    |=> first_multi_pin_oe_o && !first_multi_pin_o)
    else $error("first pin not held low");
  a_first_open: assert property (fn1 == P1_OPEN |=> !first_multi_pin_oe_o)  // see RULE16
    else $error("first pin not released");
  a_vsel_drive: assert property (fn1 == P1_VSEL  // see RULE17
    |=> first_multi_pin_oe_o && first_multi_pin_o == $past(voltage_select_line_one_i))
    else $error("voltage select not driven");
  a_bus_answer: assert property (req |=> wb_ack_o ##1 !wb_ack_o)  // see RULE18
    else $error("bus answer not a single cycle");
  a_reserved_hiz: assert property (fn1 > P1_VSEL |=> !first_multi_pin_oe_o)  // see RULE19
    else $error("reserved code drives first pin");

  c_ctl_write: cover property (wr && hit_ctl);
  c_lane_write: cover property (wr && hit_ctl && !wb_sel_i[0]);
  c_pwm_toggle: cover property (fn3 == P3_PWM ##1 $rose(third_multi_pin_oe_o));
  c_delay_release: cover property (fn3 == P3_OFF_DELAY && $fell(delay_hold));
  c_arb_grant: cover property ($rose(bus_master_arbitration_grant_o));

endmodule

// >>> tb/board_model.sv
`timescale 1ns/1ns
module board_model (
  input  wire logic [2:0] dev_o_i,      // Design drive values
  input  wire logic [2:0] dev_oe_i,     // Design drive enables
  input  wire logic [2:0] drive_en_i,   // Board drives the pin
  input  wire logic [2:0] drive_val_i,  // Board drive level
  output logic      [2:0] pad_o         // Resolved pin level
);
  // Pull-up on every pin; contention reads as the inverse of the design value
  assign pad_o = (dev_oe_i & drive_en_i & ~dev_o_i)
               | (dev_oe_i & ~drive_en_i & dev_o_i)
               | (~dev_oe_i & drive_en_i & drive_val_i)
               | (~dev_oe_i & ~drive_en_i);
endmodule

// >>> tb/tb.sv
`timescale 1ns/1ns
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end
module tb;
  import pin_function_pkg::*;
  localparam int OFF_CYC = 20;
  localparam int PER     = 100;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00, duty;
  logic [31:0] wdat = 32'h0, rnd = 32'h75F23ED6, rdat;
  logic [17:0] ins = 18'h0;
  logic [2:0]  pin_o, pin_oe, pad;
  logic        ack, batt, share, sense;
  logic [3:0]  sel = 4'hF, lanes = 4'hF;
  logic [63:0] q[$], note;
  int          err_total = 0, n_compared = 0, cyc_cnt = 0, lows;

  always #4 clk_i = ~clk_i;

  pin_function_select #(.OFF_DELAY_CYCLES(OFF_CYC), .PWM_PERIOD(PER)) i_pin_function_select (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .third_multi_pin_i(pad[2]), .third_multi_pin_o(pin_o[2]), .third_multi_pin_oe_o(pin_oe[2]),
    .second_multi_pin_i(pad[1]), .second_multi_pin_o(pin_o[1]),
    .second_multi_pin_oe_o(pin_oe[1]),
    .first_multi_pin_i(pad[0]), .first_multi_pin_o(pin_o[0]), .first_multi_pin_oe_o(pin_oe[0]),
    .attached_i(ins[17]), .cc_second_i(ins[16]), .contract_sel_i(ins[15:13]),
    .qc2_mode_i(ins[12]), .quick_twelve_volt_enable_i(ins[11]),
    .quick_nine_volt_enable_i(ins[10]), .voltage_select_line_one_i(ins[9]),
    .power_budget_share_claim_i(ins[8]), .bus_master_arbitration_claim_i(ins[7]),
    .ext_enable_i(ins[6]), .device_enable_o(), .bus_master_arbitration_grant_o(),
    .converter_alert_seen_o(), .power_budget_share_level_o(share), .battery_level_sense_o(batt),
    .line_drop_current_sense_o(sense));

  board_model i_board_model (.dev_o_i(pin_o), .dev_oe_i(pin_oe), .drive_en_i(ins[5:3]),
    .drive_val_i(ins[2:0]), .pad_o(pad));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  task close_out();
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Read notes hold {mask, expected}
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [63:0] e);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= lanes;
    if (!w) q.push_back(e);
    do @(posedge clk_i); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // Set side inputs, write the control word, then read the status bits under mask
  task run(input logic [15:0] c, input logic [17:0] s, input logic [6:0] e, input logic [6:0] m);
    @(posedge clk_i);
    ins <= s;
    rnd = xs(rnd);
    wb(1'b1, CTL_ADDR, {16'h0000, rnd[6:0], c[8:0]}, 64'h0);
    repeat (8) @(posedge clk_i);
    wb(1'b0, STAT_ADDR, 32'h0, {25'h0, m, 25'h0, e});
  endtask

  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0) begin
      note = q.pop_front();
      `CHK(rdat & note[63:32], note[31:0])
    end
  end

  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      err_total++;
      close_out();
    end
  end

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, CTL_ADDR, 32'h0, {32'h0000FFFF, 32'h00000031});
    wb(1'b0, DUTY_ADDR, 32'h0, {32'h000000FF, 32'h00000080});
    wb(1'b0, 8'h08, 32'h0, {32'hFFFFFFFF, 32'h00000000});
    wb(1'b1, CTL_ADDR, 32'h0000A5B4, 64'h0);
    wb(1'b0, CTL_ADDR, 32'h0, {32'h0000FFFF, 32'h0000A5B4});
    lanes = 4'h2;
    wb(1'b1, CTL_ADDR, 32'h00001234, 64'h0);
    lanes = 4'hF;
    wb(1'b0, CTL_ADDR, 32'h0, {32'h0000FFFF, 32'h000012B4});
    run(16'h0198, 18'h04000, 7'h00, 7'h01);
    run(16'h0198, 18'h01400, 7'h00, 7'h01);
    run(16'h0198, 18'h00000, 7'h01, 7'h01);
    run(16'h0199, 18'h00008, 7'h40, 7'h41);
    run(16'h0199, 18'h00000, 7'h01, 7'h41);
    run(16'h019A, 18'h00000, 7'h00, 7'h01);
    run(16'h019B, 18'h00000, 7'h01, 7'h01);
    run(16'h019C, 18'h00000, 7'h00, 7'h01);
    run(16'h019C, 18'h00200, 7'h01, 7'h01);
    `CHK(pin_oe[0], 1'b1)
    for (int k = 5; k < 8; k++) begin
      run(16'h0198 | 16'(k), 18'h00000, 7'h01, 7'h01);
      `CHK(pin_oe[0], 1'b0)
    end
    run(16'h0183, 18'h01000, 7'h00, 7'h02);
    run(16'h0183, 18'h01800, 7'h02, 7'h02);
    run(16'h018B, 18'h00000, 7'h00, 7'h02);
    run(16'h018B, 18'h10000, 7'h02, 7'h02);
    run(16'h0193, 18'h00000, 7'h00, 7'h02);
    for (int k = 3; k < 6; k++) begin
      run(16'h0183 | 16'(k << 3), 18'h00000, 7'h02, 7'h02);
      `CHK(pin_oe[1], 1'b0)
    end
    run(16'h01B3, 18'h00100, 7'h00, 7'h02);
    `CHK(share, 1'b0)
    run(16'h01B3, 18'h00000, 7'h02, 7'h02);
    `CHK(share, 1'b1)
    run(16'h01BB, 18'h00010, 7'h00, 7'h02);
    `CHK(batt, 1'b0)
    run(16'h01BB, 18'h00000, 7'h02, 7'h02);
    `CHK(batt, 1'b1)
    run(16'h001B, 18'h000A0, 7'h00, 7'h20);
    `CHK(pin_oe[2], 1'b0)
    run(16'h001B, 18'h00080, 7'h20, 7'h24);
    run(16'h005B, 18'h00020, 7'h00, 7'h08);
    run(16'h005B, 18'h00024, 7'h08, 7'h08);
    run(16'h009B, 18'h20000, 7'h00, 7'h04);
    run(16'h009B, 18'h00000, 7'h04, 7'h04);
    run(16'h011B, 18'h00000, 7'h00, 7'h04);
    run(16'h011B, 18'h10000, 7'h04, 7'h04);
    run(16'h015B, 18'h06000, 7'h00, 7'h04);
    run(16'h015B, 18'h04000, 7'h04, 7'h04);
    run(16'h019B, 18'h00020, 7'h00, 7'h04);
    `CHK(pin_oe[2], 1'b0)
    `CHK(sense, 1'b0)
    run(16'h019B, 18'h00000, 7'h04, 7'h04);
    `CHK(sense, 1'b1)
    run(16'h00DB, 18'h00040, 7'h14, 7'h14);
    @(posedge clk_i);
    ins <= 18'h0;
    repeat (10) @(posedge clk_i);
    `CHK(pin_oe[2], 1'b1)
    repeat (20) @(posedge clk_i);
    `CHK(pin_oe[2], 1'b0)
    for (int k = 0; k < 2; k++) begin
      rnd = xs(rnd);
      duty = (k == 0) ? 8'h00 : rnd[7:0];
      wb(1'b1, DUTY_ADDR, {24'h0, duty}, 64'h0);
      run(16'h01DB, 18'h00000, 7'h00, 7'h00);
      lows = 0;
      repeat (PER) begin
        @(posedge clk_i);
        if (pin_oe[2] === 1'b1 && pin_o[2] === 1'b0) lows++;
      end
      `CHK(lows, PER - (PER * int'(duty)) / 256)
    end
    close_out();
  end
endmodule
